// ==== scs_channel_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scs_regs.svh"
module scs_channel_select #(
    parameter int BIT_CYCLES = `SCS_BIT_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              serRx,
    output logic                   serTx,
    input  wire scs_pkg::scs_mode_t portMode,
    input  wire logic              localSelValid,
    input  wire scs_pkg::scs_sel_t localSel,
    output scs_pkg::scs_sel_t      selOut,
    output logic                   selChanged
);
    typedef enum logic [2:0] {
        SCS_RX_IDLE  = 3'b001,
        SCS_RX_DATA  = 3'b010,
        SCS_RX_STOP  = 3'b100
    } scs_rx_state_t;

    logic              rxMeta;
    logic              rxSync;
    scs_rx_state_t     rxState;
    logic [15:0]       rxDiv;
    logic [2:0]        rxBit;
    logic [7:0]        rxShift;
    logic              rxStrobe;
    logic [7:0]        rxByte;
    logic              rxTick;
    logic              codeValid;
    scs_pkg::scs_sel_t codeSel;
    scs_pkg::scs_sel_t sel_reg;
    logic              pendReg;
    logic [7:0]        pendCode;
    logic              txReady;
    logic              syncMode;

    // Pin passes two flops before the receiver looks at it.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
        end else begin
            rxMeta <= serRx;
            rxSync <= rxMeta;
        end
    end

    assign rxTick = (rxDiv == 16'h0000);

    // Receiver samples mid-bit; no ready is ever offered to the sender.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rxState  <= SCS_RX_IDLE;
            rxDiv    <= 16'h0000;
            rxBit    <= 3'h0;
            rxShift  <= 8'h00;
            rxStrobe <= 1'b0;
            rxByte   <= 8'h00;
        end else begin
            rxStrobe <= 1'b0;
            rxDiv    <= rxTick ? 16'(BIT_CYCLES - 1) : rxDiv - 16'h0001;
            unique case (rxState)
                SCS_RX_IDLE: begin
                    if (!rxSync) begin
                        rxDiv   <= 16'(BIT_CYCLES + BIT_CYCLES / 2 - 1);
                        rxBit   <= 3'h0;
                        rxState <= SCS_RX_DATA;
                    end
                end
                SCS_RX_DATA: begin
                    if (rxTick) begin
                        rxShift <= {rxSync, rxShift[7:1]};
                        rxBit   <= rxBit + 3'h1;
                        if (rxBit == 3'h7) begin
                            rxState <= SCS_RX_STOP;
                        end
                    end
                end
                SCS_RX_STOP: begin
                    // A framing error drops the byte; no parity bit exists.
                    if (rxTick) begin
                        rxState <= SCS_RX_IDLE;
                        if (rxSync) begin
                            rxStrobe <= 1'b1;
                            rxByte   <= rxShift;
                        end
                    end
                end
            endcase
        end
    end

    assign syncMode = (portMode == scs_pkg::SCS_MODE_SYNC);

    always_comb begin
        codeSel   = '{blank: 1'b0, channel: 5'(rxByte[3:0] + 4'h1)};
        codeValid = 1'b0;
        if (rxByte >= `SCS_CODE_CH_FIRST && rxByte <= `SCS_CODE_CH_LAST) begin
            codeValid = 1'b1;
            codeSel   = '{blank: 1'b0, channel: 5'(rxByte[3:0]) + 5'h01};
        end else if (rxByte == `SCS_CODE_BLANK) begin
            codeValid = 1'b1;
            codeSel   = '{blank: 1'b1, channel: 5'h00};
        end
    end

    function automatic logic [7:0] selCode(input scs_pkg::scs_sel_t s);
        if (s.blank || s.channel == 5'h00) begin
            selCode = `SCS_CODE_BLANK;
        end else begin
            selCode = `SCS_CODE_CH_FIRST + {4'h0, 4'(s.channel - 5'h01)};
        end
    endfunction : selCode

    // Serial codes win over a local request in the same cycle.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sel_reg    <= '{blank: 1'b0, channel: 5'h01};
            selChanged <= 1'b0;
        end else begin
            selChanged <= 1'b0;
            if (rxStrobe && syncMode && codeValid) begin
                sel_reg    <= codeSel;
                selChanged <= (codeSel != sel_reg);
            end else if (localSelValid) begin
                sel_reg    <= localSel;
                selChanged <= (localSel != sel_reg);
            end
        end
    end
    assign selOut = sel_reg;

    // One pending code; a newer one overwrites an unsent one, since only the
    // latest selection matters to following units.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pendReg  <= 1'b0;
            pendCode <= 8'h00;
        end else begin
            if (rxStrobe && syncMode && codeValid) begin
                pendReg  <= 1'b1;
                pendCode <= rxByte;
            end else if (localSelValid && syncMode && localSel != sel_reg) begin
                pendReg  <= 1'b1;
                pendCode <= selCode(localSel);
            end else if (txReady) begin
                pendReg  <= 1'b0;
            end
        end
    end

    scs_uart_tx #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_tx (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .txValid  (pendReg),
        .txData   (pendCode),
        .txReady  (txReady),
        .txLine   (serTx)
    );
endmodule : scs_channel_select
`default_nettype wire

// ==== scs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module scs_chk (
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire logic               serRx,
    input wire logic               serTx,
    input wire scs_pkg::scs_mode_t portMode,
    input wire logic               localSelValid,
    input wire scs_pkg::scs_sel_t  localSel,
    input wire scs_pkg::scs_sel_t  selOut,
    input wire logic               selChanged
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_off4; (portMode != scs_pkg::SCS_MODE_SYNC)[*4]; endsequence
    sequence s_upd; selChanged && portMode == scs_pkg::SCS_MODE_SYNC; endsequence
    a_chg_pulse: assert property (selChanged |=> !selChanged) else $error("long pulse");
    a_chg_value: assert property (selChanged |-> selOut != $past(selOut)) else $error("no change");
    a_sel_hold: assert property (!selChanged |-> $stable(selOut)) else $error("silent change");
    // A local request may still move the selection outside unit-follow mode.
    a_mode_gate: assert property (s_off4 ##0 !$past(localSelValid) |-> !selChanged)
        else $error("acted off mode");
    a_blank_zero: assert property (selOut.blank |-> selOut.channel == 5'h00) else $error("blank");
    a_chan_range: assert property (!selOut.blank |-> selOut.channel inside {[5'h01:5'h10]})
        else $error("channel range");
    a_tx_answer: assert property (s_upd |-> ##[1:200] !serTx) else $error("no code sent");
    a_bit_low: assert property ($fell(serTx) |-> !serTx[*8]) else $error("short low bit");
    a_bit_high: assert property ($rose(serTx) |-> serTx[*8]) else $error("short high bit");
endmodule : scs_chk
bind scs_channel_select scs_chk scs_chk_i (.core_clk(core_clk), .rst_n(rst_n), .serRx(serRx),
    .serTx(serTx), .portMode(portMode), .localSelValid(localSelValid), .localSel(localSel),
    .selOut(selOut), .selChanged(selChanged));
`default_nettype wire

// ==== scs_pkg.sv ====
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_MODE_POWER   = 2'h0,
        SCS_MODE_SYNC    = 2'h1,
        SCS_MODE_CONSOLE = 2'h2,
        SCS_MODE_OFF     = 2'h3
    } scs_mode_t;
    typedef struct packed {
        logic       blank;
        logic [4:0] channel;
    } scs_sel_t;
endpackage : scs_pkg

// ==== scs_regs.svh ====
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH
`define SCS_CLK_HZ        250000000
`define SCS_BAUD          19200
`define SCS_BIT_CYCLES    (`SCS_CLK_HZ / `SCS_BAUD)
`define SCS_DATA_BITS     8
`define SCS_CODE_CH_FIRST 8'h10
`define SCS_CODE_CH_LAST  8'h1F
`define SCS_CODE_BLANK    8'h71
`endif

// ==== scs_remote.sv ====
`timescale 1ns/1ps
`default_nettype none
module scs_remote #(
    parameter int BIT = 16
) (
    input wire logic core_clk,
    output logic     serRx,
    input wire logic serTx
);
    logic [7:0] rxByte;
    int         rxCount = 0;
    initial serRx = 1'b1;
    // The sender never waits on any handshake from the device.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            serRx <= f[i];
            repeat (BIT - 1) @(posedge core_clk);
        end
    endtask : send
    always begin
        @(negedge serTx);
        repeat (BIT / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge core_clk);
            rxByte[i] = serTx;
        end
        repeat (BIT) @(posedge core_clk);
        if (serTx === 1'b1) rxCount++;
    end
endmodule : scs_remote
`default_nettype wire

// ==== scs_uart_tx.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scs_regs.svh"
module scs_uart_tx #(
    parameter int BIT_CYCLES = `SCS_BIT_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       txValid,
    input  wire logic [7:0] txData,
    output logic            txReady,
    output logic            txLine
);
    typedef enum logic [1:0] {
        SCS_TX_IDLE = 2'b01,
        SCS_TX_BUSY = 2'b10
    } scs_tx_state_t;
    scs_tx_state_t stateReg;
    logic [15:0]   divReg;
    logic [3:0]    bitReg;
    logic [9:0]    shiftReg;
    logic          tick;
    assign tick    = (divReg == 16'(BIT_CYCLES - 1));
    assign txReady = (stateReg == SCS_TX_IDLE);
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stateReg <= SCS_TX_IDLE;
            divReg   <= 16'h0000;
            bitReg   <= 4'h0;
            shiftReg <= 10'h3FF;
            txLine   <= 1'b1;
        end else begin
            unique case (stateReg)
                SCS_TX_IDLE: begin
                    txLine <= 1'b1;
                    if (txValid) begin
                        // Start bit, eight data bits lsb first, one stop bit.
                        shiftReg <= {1'b1, txData, 1'b0};
                        stateReg <= SCS_TX_BUSY;
                        divReg   <= 16'h0000;
                        bitReg   <= 4'h0;
                    end
                end
                SCS_TX_BUSY: begin
                    txLine <= shiftReg[0];
                    divReg <= tick ? 16'h0000 : divReg + 16'h0001;
                    if (tick) begin
                        shiftReg <= {1'b1, shiftReg[9:1]};
                        bitReg   <= bitReg + 4'h1;
                        if (bitReg == 4'h9) begin
                            stateReg <= SCS_TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule : scs_uart_tx
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int BIT = 16;
    logic               core_clk, rst_n, localSelValid, serRx, serTx, selChanged;
    scs_pkg::scs_mode_t portMode;
    scs_pkg::scs_sel_t  localSel, selOut;
    int                 nFail = 0, checked = 0, cycles = 0, nChg = 0;
    scs_channel_select #(.BIT_CYCLES(BIT)) scs_channel_select_i (.core_clk(core_clk),
        .rst_n(rst_n), .serRx(serRx), .serTx(serTx), .portMode(portMode),
        .localSelValid(localSelValid), .localSel(localSel), .selOut(selOut),
        .selChanged(selChanged));
    scs_remote #(.BIT(BIT)) scs_remote_i (.core_clk(core_clk), .serRx(serRx), .serTx(serTx));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (selChanged === 1'b1) nChg++;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            testDone();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Fixed wait after the frame in covers the echo frame out with margin.
    task automatic xfer(input logic [7:0] c, input logic echo, input logic [7:0] sel);
        int n0;
        n0 = scs_remote_i.rxCount;
        scs_remote_i.send(c);
        repeat (14 * BIT) @(posedge core_clk);
        chk(8'(scs_remote_i.rxCount - n0), {7'h00, echo});
        if (echo) chk(scs_remote_i.rxByte, c);
        chk({2'h0, selOut}, sel);
    endtask : xfer
    task automatic tCodes();
        int c0;
        c0 = nChg;
        for (int c = 16; c < 32; c++) xfer(8'(c), 1'b1, 8'(c - 15));
        xfer(8'h71, 1'b1, 8'h20);
        chk(8'(nChg - c0), 8'h10);
    endtask : tCodes
    task automatic tBad();
        logic [7:0] bad [4] = '{8'h0F, 8'h20, 8'h70, 8'hFF};
        int         c0;
        c0 = nChg;
        foreach (bad[i]) xfer(bad[i], 1'b0, 8'h20);
        chk(8'(nChg - c0), 8'h00);
    endtask : tBad
    task automatic tMode();
        scs_pkg::scs_mode_t m [3] = '{scs_pkg::SCS_MODE_POWER, scs_pkg::SCS_MODE_CONSOLE,
                                      scs_pkg::SCS_MODE_OFF};
        int                 c0;
        c0 = nChg;
        foreach (m[i]) begin
            @(posedge core_clk);
            portMode <= m[i];
            xfer(8'h13, 1'b0, 8'h20);
        end
        chk(8'(nChg - c0), 8'h00);
    endtask : tMode
    task automatic tLocal();
        int n0;
        int c0;
        n0 = scs_remote_i.rxCount;
        c0 = nChg;
        @(posedge core_clk);
        portMode <= scs_pkg::SCS_MODE_SYNC;
        localSel <= '{blank: 1'b0, channel: 5'h07};
        localSelValid <= 1'b1;
        @(posedge core_clk);
        localSelValid <= 1'b0;
        repeat (14 * BIT) @(posedge core_clk);
        chk({2'h0, selOut}, 8'h07);
        chk(8'(scs_remote_i.rxCount - n0), 8'h01);
        chk(scs_remote_i.rxByte, 8'h16);
        chk(8'(nChg - c0), 8'h01);
    endtask : tLocal
    task automatic testDone();
        if (nFail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : testDone
    initial begin
        rst_n = 1'b0;
        portMode = scs_pkg::SCS_MODE_SYNC;
        localSelValid = 1'b0;
        localSel = '0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk({2'h0, selOut}, 8'h01);
        tCodes();
        tBad();
        tMode();
        tLocal();
        testDone();
    end
endmodule : tb
`default_nettype wire
